/* File: verilog/pmx_top.sv */
// Pin ownership arbiter for sixteen remappable general purpose pins.
// Assumes peripheral and port controls come from logic on the same clock;
// the pad input levels are asynchronous and are synchronised here.
// What this block does
// - Fixed priority per pin; the port function is lowest.
// - Two enabled peripherals on one pin: only the higher one drives.
// - Input-only functions never claim the output driver.
// - Input-only pin set to output: latch drives pin and peripheral input.
// - Interrupt, timer clock, capture, fault inputs follow the latch when output.
// - Serial and encoder peripherals own their pins fully when enabled.
// - Module-controlled peripheral disables the port driver on its pin.
// - Software sets direction for user-settable pins; reads return pin level.
// - Interrupt pin as output feeds its latch value to the detector.
// - Enabled UART ignores direction and pin-value registers on its pins.
// - Unused peripheral pin acts as port output when direction is zero.
// - Up to sixteen remappable pins, each with an index.
// - Each remappable input and output is assigned independently.
// - Two-wire bus and analog functions never remap; fixed pins only.
// - Fixed peripherals use their default pin under normal priority.
// - Remapped peripheral outranks every other digital function on a pin.
// - Analog functions outrank any remapped peripheral.
// - Direction one is input, zero is output; all inputs after reset.
// - Latch reads give latch, pin-value reads give port-owned pins, zero elsewhere; writes update latch.
// - Output select zero is the null choice, leaving the port function.
// - Each remapped input is chosen by a five-bit pin index.
`timescale 1ns/1ps
`default_nettype none
module pmx_top
   import pmx_pkg::*;
(
   input wire logic clock,
   input wire logic resetn,
   // Port register write strobes; lat_wr and pin_wr both write the latch
   input wire logic dir_wr,
   input wire logic [NPIN-1:0] dir_wdata,
   input wire logic lat_wr,
   input wire logic pin_wr,
   input wire logic [NPIN-1:0] lat_wdata,
   // Per-pin output select, five bits per pin
   input wire logic out_sel_wr,
   input wire logic [NPIN*SELW-1:0] out_sel_wdata,
   // Per-peripheral input select, five bits per remappable input
   input wire logic in_sel_wr,
   input wire logic [NRIN*SELW-1:0] in_sel_wdata,
   // Remappable peripheral outputs, indexed by their select code
   input wire logic [31:0] remap_out_data,
   // Fixed peripherals: A outranks B; each has a module-control flag
   input wire logic [NPIN-1:0] fix_a_en,
   input wire logic [NPIN-1:0] fix_a_modctl,
   input wire logic [NPIN-1:0] fix_a_data,
   input wire logic [NPIN-1:0] fix_a_oe,
   input wire logic [NPIN-1:0] fix_b_en,
   input wire logic [NPIN-1:0] fix_b_modctl,
   input wire logic [NPIN-1:0] fix_b_data,
   input wire logic [NPIN-1:0] fix_b_oe,
   input wire logic [NPIN-1:0] analog_en,
   input wire logic [NPIN-1:0] pad_in,
   output logic [NPIN-1:0] pad_out,
   output logic [NPIN-1:0] pad_oe,
   output logic [NPIN-1:0] direction_reg,
   output logic [NPIN-1:0] output_latch_reg,
   output logic [NPIN-1:0] pin_value_reg,
   output logic [NRIN-1:0] remap_in_data,
   output logic [NPIN-1:0] fix_in_data,
   output logic [NPIN*SELW-1:0] out_sel,
   output logic [NRIN*SELW-1:0] in_sel,
   output logic [2*NPIN-1:0] pin_owner
);

   logic [NPIN-1:0] pad_meta;
   logic [NPIN-1:0] pad_sync;
   logic [NPIN-1:0] next_dir;
   logic [NPIN-1:0] next_lat;
   logic [NPIN*SELW-1:0] next_out_sel;
   logic [NRIN*SELW-1:0] next_in_sel;
   logic [NPIN-1:0] next_pad_out;
   logic [NPIN-1:0] next_pad_oe;
   logic [NPIN-1:0] next_pin_val;
   logic [NRIN-1:0] next_rin;
   logic [NPIN-1:0] next_fin;
   logic [2*NPIN-1:0] next_owner;

   // Pin level seen by the core: the driven value while driving, else the pad
   function automatic logic level_of(input logic oe, input logic drv, input logic pad);
      level_of = oe ? drv : pad;
   endfunction : level_of

   // A select code names a peripheral output; unknown codes act as null
   function automatic logic code_valid(input logic [SELW-1:0] c);
      case (c)
         SEL_UART_TX, SEL_UART_RTS, SEL_SPI_DO, SEL_SPI_CLK, SEL_SPI_SS,
         SEL_CMP1, SEL_CMP2, SEL_ENC_DIR: code_valid = 1'b1;
         default: code_valid = 1'b0;
      endcase
   endfunction : code_valid

   // Pads are asynchronous to the core; only the second stage is read
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         pad_meta <= '0;
         pad_sync <= '0;
      end else begin
         pad_meta <= pad_in;
         pad_sync <= pad_meta;
      end
   end

   // Port and select registers
   always_comb begin
      next_dir = direction_reg;
      next_lat = output_latch_reg;
      next_out_sel = out_sel;
      next_in_sel = in_sel;
      if (dir_wr) begin
         next_dir = dir_wdata;
      end
      if (lat_wr || pin_wr) begin
         next_lat = lat_wdata;
      end
      if (out_sel_wr) begin
         next_out_sel = out_sel_wdata;
      end
      if (in_sel_wr) begin
         next_in_sel = in_sel_wdata;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         direction_reg <= DIR_RESET;
         output_latch_reg <= LAT_RESET;
         out_sel <= {NPIN{SEL_NULL}};
         in_sel <= {NRIN{SEL_RIN_RESET}};
      end else begin
         direction_reg <= next_dir;
         output_latch_reg <= next_lat;
         out_sel <= next_out_sel;
         in_sel <= next_in_sel;
      end
   end

   // Ownership: analog > remapped > fixed A > fixed B > port
   always_comb begin
      logic [SELW-1:0] code;
      logic lvl;
      code = SEL_NULL;
      lvl = 1'b0;
      next_pad_out = '0;
      next_pad_oe = '0;
      next_pin_val = '0;
      next_fin = '0;
      next_owner = '0;
      for (int p = 0; p < NPIN; p++) begin
         code = out_sel[p*SELW +: SELW];
         if (analog_en[p]) begin
            next_pad_oe[p] = 1'b0;
            next_owner[2*p +: 2] = PMX_ANALOG;
         end else if (code_valid(code)) begin
            next_pad_out[p] = remap_out_data[code];
            next_pad_oe[p] = 1'b1;
            next_owner[2*p +: 2] = PMX_REMAP;
         end else if (fix_a_en[p] && fix_a_modctl[p]) begin
            next_pad_out[p] = fix_a_data[p];
            next_pad_oe[p] = fix_a_oe[p];
            next_owner[2*p +: 2] = PMX_FIXED;
         end else if (fix_b_en[p] && fix_b_modctl[p]) begin
            next_pad_out[p] = fix_b_data[p];
            next_pad_oe[p] = fix_b_oe[p];
            next_owner[2*p +: 2] = PMX_FIXED;
         end else begin
            // Input-only and unused functions leave the port in charge
            next_pad_out[p] = output_latch_reg[p];
            next_pad_oe[p] = !direction_reg[p];
            next_owner[2*p +: 2] = PMX_PORT;
         end
         lvl = level_of(next_pad_oe[p], next_pad_out[p], pad_sync[p]);
         // Module-controlled pins hide their level from the port path
         if (next_owner[2*p +: 2] == PMX_PORT) begin
            next_pin_val[p] = lvl;
         end else begin
            next_pin_val[p] = 1'b0;
         end
         next_fin[p] = lvl;
      end
      for (int i = 0; i < NRIN; i++) begin
         code = in_sel[i*SELW +: SELW];
         if (code < SELW'(NPIN)) begin
            next_rin[i] = level_of(next_pad_oe[code[3:0]], next_pad_out[code[3:0]],
                                   pad_sync[code[3:0]]);
         end else begin
            next_rin[i] = 1'b0;
         end
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         pad_out <= '0;
         pad_oe <= '0;
         pin_value_reg <= '0;
         remap_in_data <= '0;
         fix_in_data <= '0;
         pin_owner <= '0;
      end else begin
         pad_out <= next_pad_out;
         pad_oe <= next_pad_oe;
         pin_value_reg <= next_pin_val;
         remap_in_data <= next_rin;
         fix_in_data <= next_fin;
         pin_owner <= next_owner;
      end
   end

endmodule : pmx_top
`default_nettype wire

/* File: verilog/pmx_pkg.sv */
// Package for the pin ownership and remap priority block.
// Assumes one system clock; all widths fixed at the documented values.
package pmx_pkg;
   localparam int NPIN = 16;
   localparam int SELW = 5;
   localparam int NRIN = 8;
   localparam int NFIX = 2;
   localparam logic [NPIN-1:0] DIR_RESET = 16'hFFFF;
   localparam logic [NPIN-1:0] LAT_RESET = 16'h0000;
   localparam logic [SELW-1:0] SEL_NULL = 5'h00;
   localparam logic [SELW-1:0] SEL_UART_TX = 5'h03;
   localparam logic [SELW-1:0] SEL_UART_RTS = 5'h04;
   localparam logic [SELW-1:0] SEL_SPI_DO = 5'h07;
   localparam logic [SELW-1:0] SEL_SPI_CLK = 5'h08;
   localparam logic [SELW-1:0] SEL_SPI_SS = 5'h09;
   localparam logic [SELW-1:0] SEL_CMP1 = 5'h12;
   localparam logic [SELW-1:0] SEL_CMP2 = 5'h13;
   localparam logic [SELW-1:0] SEL_ENC_DIR = 5'h1A;
   localparam logic [SELW-1:0] SEL_RIN_RESET = 5'h1F;

   typedef struct packed {
      logic en;
      logic data;
      logic oe;
   } pmx_drive_s;

   typedef enum logic [1:0] {
      PMX_PORT = 2'b00,
      PMX_FIXED = 2'b01,
      PMX_REMAP = 2'b10,
      PMX_ANALOG = 2'b11
   } pmx_owner_e;
endpackage : pmx_pkg

/* File: verif/pmx_asserts.sv */
// Checker of pad ownership and register writes on pin 0 and the register ports.
// Assumes it is bound onto pmx_top, all in one clock domain.
`timescale 1ns/1ps
`default_nettype none
module pmx_asserts
   import pmx_pkg::*;
(
   input wire logic clock,
   input wire logic resetn,
   input wire logic dir_wr,
   input wire logic lat_wr,
   input wire logic pin_wr,
   input wire logic out_sel_wr,
   input wire logic [NPIN-1:0] dir_wdata,
   input wire logic [NPIN-1:0] lat_wdata,
   input wire logic [NPIN-1:0] fix_a_en,
   input wire logic [NPIN-1:0] fix_a_modctl,
   input wire logic [NPIN-1:0] fix_a_data,
   input wire logic [NPIN-1:0] fix_a_oe,
   input wire logic [NPIN-1:0] fix_b_en,
   input wire logic [NPIN-1:0] fix_b_modctl,
   input wire logic [NPIN-1:0] analog_en,
   input wire logic [NPIN-1:0] pad_out,
   input wire logic [NPIN-1:0] pad_oe,
   input wire logic [NPIN-1:0] direction_reg,
   input wire logic [NPIN-1:0] output_latch_reg,
   input wire logic [NPIN*SELW-1:0] out_sel_wdata,
   input wire logic [NPIN*SELW-1:0] out_sel,
   input wire logic [31:0] remap_out_data,
   input wire logic [2*NPIN-1:0] pin_owner
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   logic mod0;
   assign mod0 = (fix_a_en[0] && fix_a_modctl[0]) || (fix_b_en[0] && fix_b_modctl[0]);
   dir_write_a: assert property (dir_wr |=> direction_reg == $past(dir_wdata))
      else $error("direction write lost");
   dir_hold_a: assert property (!dir_wr |=> $stable(direction_reg))
      else $error("direction moved without a write");
   latch_write_a: assert property (lat_wr || pin_wr |=> output_latch_reg == $past(lat_wdata))
      else $error("latch write lost");
   sel_write_a: assert property (out_sel_wr |=> out_sel == $past(out_sel_wdata))
      else $error("output select write lost");
   analog_off_a: assert property (analog_en[0] |=>
      !pad_oe[0] && pin_owner[1:0] == PMX_ANALOG) else $error("analog pin still driven");
   fixed_wins_a: assert property (fix_a_en[0] && fix_a_modctl[0] &&
      !analog_en[0] && out_sel[4:0] == SEL_NULL |=> pin_owner[1:0] == PMX_FIXED &&
      pad_oe[0] == $past(fix_a_oe[0]) && (!pad_oe[0] || pad_out[0] == $past(fix_a_data[0])))
      else $error("higher fixed peripheral not driving");
   port_own_a: assert property (!mod0 && !analog_en[0] &&
      out_sel[4:0] == SEL_NULL |=> pin_owner[1:0] == PMX_PORT && pad_oe[0] ==
      !$past(direction_reg[0]) && (!pad_oe[0] || pad_out[0] == $past(output_latch_reg[0])))
      else $error("port function not driving a free pin");
   remap_wins_a: assert property (!analog_en[0] &&
      out_sel[4:0] == SEL_UART_TX |=> pin_owner[1:0] == PMX_REMAP && pad_oe[0] &&
      pad_out[0] == $past(remap_out_data[SEL_UART_TX])) else $error("remap output lost");
   cover property (pin_owner[1:0] == PMX_REMAP);
   cover property (pin_owner[1:0] == PMX_ANALOG);
   cover property (fix_a_en[0] && fix_b_en[0] ##1 pin_owner[1:0] == PMX_FIXED);
endmodule : pmx_asserts
bind pmx_top pmx_asserts u_chk (.clock, .resetn, .dir_wr, .lat_wr, .pin_wr, .out_sel_wr,
   .dir_wdata, .lat_wdata, .fix_a_en, .fix_a_modctl, .fix_a_data, .fix_a_oe, .fix_b_en,
   .fix_b_modctl, .analog_en, .pad_out, .pad_oe, .direction_reg, .output_latch_reg,
   .out_sel_wdata, .out_sel, .remap_out_data, .pin_owner);
`default_nettype wire

/* File: verif/pmx_partner.sv */
// Pad model: resolves each pad from the block's drive and an outside driver.
// The block's drive wins when both drive one pad; no pull resistors on pads.
`timescale 1ns/1ps
`default_nettype none
module pmx_partner
   import pmx_pkg::*;
(
   input wire logic clock,
   input wire logic [NPIN-1:0] pad_out,
   input wire logic [NPIN-1:0] pad_oe,
   input wire logic [NPIN-1:0] ext_en,
   input wire logic [NPIN-1:0] ext_val,
   output logic [NPIN-1:0] pad_in
);
   logic [NPIN-1:0] float_val = '0;
   // A floating pad wanders every cycle so a stale level can never pass a check
   always @(posedge clock) float_val <= ~float_val;
   assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
      | (~pad_oe & ~ext_en & float_val);
endmodule : pmx_partner
`default_nettype wire

/* File: verif/tb.sv */
// Self-checking bench for pmx_top with a pad model on the far side.
// Assumes registered pads settle within four edges of any input change.
`timescale 1ns/1ps
`default_nettype none
module tb
   import pmx_pkg::*;
;
   logic clock = 0, resetn = 0, dir_wr = 0, lat_wr = 0, pin_wr = 0, out_sel_wr = 0, in_sel_wr = 0;
   logic [NPIN-1:0] dir_wdata = '0, lat_wdata = '0, fix_a_en = '0, fix_a_modctl = '0;
   logic [NPIN-1:0] fix_a_data = '0, fix_a_oe = '0, fix_b_en = '0, fix_b_modctl = '0;
   logic [NPIN-1:0] fix_b_data = '0, fix_b_oe = '0, analog_en = '0, ext_en = '0, ext_val = '0;
   logic [NPIN-1:0] pad_in, pad_out, pad_oe, direction_reg, output_latch_reg, pin_value_reg;
   logic [NPIN-1:0] fix_in_data;
   logic [NPIN*SELW-1:0] out_sel_wdata = '0, out_sel;
   logic [NRIN*SELW-1:0] in_sel_wdata = '0, in_sel;
   logic [NRIN-1:0] remap_in_data;
   logic [31:0] remap_out_data = '0;
   logic [2*NPIN-1:0] pin_owner;
   logic [SELW-1:0] codes[8] = '{SEL_UART_TX, SEL_UART_RTS, SEL_SPI_DO, SEL_SPI_CLK,
      SEL_SPI_SS, SEL_CMP1, SEL_CMP2, SEL_ENC_DIR};
   int err_total = 0, checks_done = 0;
   pmx_top dut (.clock, .resetn, .dir_wr, .dir_wdata, .lat_wr, .pin_wr, .lat_wdata, .out_sel_wr,
      .out_sel_wdata, .in_sel_wr, .in_sel_wdata, .remap_out_data, .fix_a_en, .fix_a_modctl,
      .fix_a_data, .fix_a_oe, .fix_b_en, .fix_b_modctl, .fix_b_data, .fix_b_oe, .analog_en,
      .pad_in, .pad_out, .pad_oe, .direction_reg, .output_latch_reg, .pin_value_reg,
      .remap_in_data, .fix_in_data, .out_sel, .in_sel, .pin_owner);
   pmx_partner far (.clock, .pad_out, .pad_oe, .ext_en, .ext_val, .pad_in);
   always #5 clock = ~clock;
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task automatic settle;
      repeat (4) @(posedge clock);
      #1;
   endtask : settle
   task automatic pulse(ref logic s);
      s = 1;
      @(posedge clock);
      #1 s = 0;
      settle();
   endtask : pulse
   task automatic final_report;
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : final_report
   initial begin
      #20000;
      err_total++;
      final_report();
   end
   initial begin
      repeat (16) @(posedge clock);
      #1 resetn = 1;
      chk("dir_reset", direction_reg, DIR_RESET);
      chk("lat_reset", output_latch_reg, LAT_RESET);
      chk("sel_reset", out_sel[SELW-1:0], SEL_NULL);
      chk("in_sel_reset", in_sel[SELW-1:0], SEL_RIN_RESET);
      chk("oe_reset", pad_oe, 16'h0000);
      lat_wdata = 16'hA5C3;
      pulse(lat_wr);
      dir_wdata = 16'h0000;
      pulse(dir_wr);
      chk("port_oe", pad_oe, 16'hFFFF);
      chk("port_out", pad_out, 16'hA5C3);
      chk("pin_read", pin_value_reg, 16'hA5C3);
      // Input-only function on pin 1 leaves the port in charge, so the latch forces it
      fix_a_en[1] = 1;
      foreach (codes[i]) begin
         lat_wdata = {8'h3C, codes[i], 3'h0} | 16'h0002 * i[0];
         if (i[1])
            pulse(pin_wr);
         else
            pulse(lat_wr);
         chk("latch", output_latch_reg, lat_wdata);
         chk("forced_in", fix_in_data[1], i[0]);
         chk("owner1", pin_owner[3:2], PMX_PORT);
      end
      fix_a_en[0] = 1;
      fix_a_modctl[0] = 1;
      fix_a_data[0] = 1;
      fix_a_oe[0] = 1;
      fix_b_en[0] = 1;
      fix_b_modctl[0] = 1;
      settle();
      chk("a_wins", {pin_owner[1:0], pad_out[0]}, {PMX_FIXED, 1'b1});
      chk("hidden", pin_value_reg[0], 1'b0);
      fix_a_en[0] = 0;
      settle();
      chk("b_owns", pad_oe[0], 1'b0);
      foreach (codes[i]) begin
         remap_out_data = 32'h1 << codes[i];
         out_sel_wdata[SELW-1:0] = codes[i];
         pulse(out_sel_wr);
         chk("remap", {pin_owner[1:0], pad_oe[0], pad_out[0]}, {PMX_REMAP, 2'b11});
      end
      analog_en[0] = 1;
      settle();
      chk("analog", {pin_owner[1:0], pad_oe[0]}, {PMX_ANALOG, 1'b0});
      analog_en[0] = 0;
      fix_b_en[0] = 0;
      out_sel_wdata[SELW-1:0] = 5'h01;
      pulse(out_sel_wr);
      chk("bad_code", {pin_owner[1:0], pad_oe[0]}, {PMX_PORT, 1'b1});
      ext_en[5] = 1;
      ext_val[5] = 1;
      dir_wdata = 16'h0020;
      pulse(dir_wr);
      chk("ext_read", {pad_oe[5], pin_value_reg[5]}, 2'b01);
      in_sel_wdata[SELW-1:0] = 5'h05;
      pulse(in_sel_wr);
      chk("in_map", remap_in_data[0], 1'b1);
      in_sel_wdata[SELW-1:0] = 5'h10;
      pulse(in_sel_wr);
      chk("in_none", remap_in_data[0], 1'b0);
      final_report();
   end
endmodule : tb
`default_nettype wire
